// ---- ccpt_ms_timer.sv ----
// Millisecond one-shot timer driven by the shared tick
`timescale 1ns/1ps
module ccpt_ms_timer import ccpt_pkg::*; (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic ms_tick_i,
	input wire logic start_i,
	input wire ccpt_ms_type load_i,
	output logic done_o
);
	ccpt_ms_type cnt_reg;
	logic armed_reg;

	// One extra tick: the first tick may land right after the start
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg <= '0;
			armed_reg <= 1'b0;
		end else if (start_i) begin
			cnt_reg <= TMR_W'(load_i + 1'b1);
			armed_reg <= 1'b1;
		end else if (ms_tick_i && cnt_reg != '0) begin
			cnt_reg <= TMR_W'(cnt_reg - 1'b1);
		end
	end

	assign done_o = armed_reg && cnt_reg == '0;
endmodule

// ---- ccpt_partner_model.sv ----
// Behavioural port partner turning both ends' CC terminations into comparator levels
`timescale 1ns/1ps
module ccpt_partner_model import ccpt_pkg::*; (
	input wire logic rp_en_i,
	input wire logic rd_en_i,
	input wire ccpt_adv_type adv_cfg_i,
	input wire logic [1:0] kind_i,
	input wire ccpt_adv_type src_adv_i,
	output ccpt_cmp_type cmp_o
);
	// Far end kinds: 0 open, 1 sink, 2 powered cable, 3 source
	int mv;

	// CC level in mV; sink at 3.0 A sits above the default sink band on purpose
	always_comb begin
		mv = 0;
		if (rp_en_i && kind_i == 2'h1) begin
			mv = (adv_cfg_i == ADV_3P0) ? 1700 : 900;
		end else if (rp_en_i && kind_i == 2'h2) begin
			mv = (adv_cfg_i == ADV_3P0) ? 600 : (adv_cfg_i == ADV_1P5) ? 300 : 100;
		end else if (rp_en_i) begin
			mv = 3000;
		end else if (rd_en_i && kind_i == 2'h3) begin
			mv = (src_adv_i == ADV_3P0) ? 1600 : (src_adv_i == ADV_1P5) ? 900 : 400;
		end
	end

	// Ideal comparators, no hysteresis
	assign cmp_o = {mv > 2600, mv > 1600, mv > 1230, mv > 800, mv > 660, mv > 400, mv > 200};
endmodule

// ---- ccpt_pkg.sv ----
// Shared constants and types for the connection timing block
package ccpt_pkg;

	// Clock and millisecond prescaler
	localparam int CLK_PERIOD_PS = 25000;
	localparam int MS_PS = 1000000000;
	localparam int CYC_PER_MS = MS_PS / CLK_PERIOD_PS;

	// Millisecond timer width, enough for the longest wait
	localparam int TMR_W = 10;
	typedef logic [TMR_W-1:0] ccpt_ms_type;

	// Timer figures in ms; each timer adds one tick of slack
	localparam ccpt_ms_type T_VBUS_DIS_MS = 10'h258;  // 600, limit 650
	localparam ccpt_ms_type T_VCONN_DIS_MS = 10'h014; // 20, limit 35
	localparam ccpt_ms_type T_SRC_BASE_MS = 10'h021;  // 33 plus 0..15 jitter
	localparam ccpt_ms_type T_SNK_MS = 10'h023;       // 35
	localparam ccpt_ms_type T_TRY_MS = 10'h064;       // 100, window 75..150
	localparam ccpt_ms_type T_TRY_WAIT_MS = 10'h258;  // 600, window 400..800
	localparam ccpt_ms_type T_CC_DB_MS = 10'h096;     // 150, window 100..200
	localparam ccpt_ms_type T_PD_DB_MS = 10'h00f;     // 15, window 10..20
	localparam ccpt_ms_type T_ERR_REC_MS = 10'h01e;   // 30, least 25
	localparam logic [7:0] T_ERR_MIN_MS = 8'h19;      // 25

	// Seed of the toggle jitter generator
	localparam logic [7:0] LFSR_SEED = 8'h5a;

	typedef enum logic [1:0] {
		ADV_DEF = 2'h0,
		ADV_1P5 = 2'h1,
		ADV_3P0 = 2'h2
	} ccpt_adv_type;

	typedef enum logic [2:0] {
		CL_OPEN = 3'h0,
		CL_RA = 3'h1,
		CL_RD = 3'h2,
		CL_SRC_DEF = 3'h3,
		CL_SRC_1P5 = 3'h4,
		CL_SRC_3P0 = 3'h5
	} ccpt_cls_type;

	typedef enum logic [3:0] {
		ST_UNATT_SNK = 4'h0,
		ST_ATTW_SNK = 4'h1,
		ST_ATT_SNK = 4'h2,
		ST_TRY_WAIT_SNK = 4'h3,
		ST_UNATT_SRC = 4'h4,
		ST_ATTW_SRC = 4'h5,
		ST_ATT_SRC = 4'h6,
		ST_TRY_SRC = 4'h7,
		ST_PWR_ACC = 4'h8,
		ST_ERR_REC = 4'h9
	} ccpt_state_type;

	// Comparator outputs, one bit per threshold, high when above it
	typedef struct packed {
		logic gt_2p60;
		logic gt_1p60;
		logic gt_1p23;
		logic gt_0p80;
		logic gt_0p66;
		logic gt_0p40;
		logic gt_0p20;
	} ccpt_cmp_type;

	typedef enum logic [1:0] {
		RSP_ACK = 2'h0,
		RSP_BUSY = 2'h1,
		RSP_NAK = 2'h2
	} ccpt_rsp_type;

	typedef struct packed {
		logic slot;
		logic enter;
	} ccpt_vdm_req_type;

	typedef struct packed {
		logic slot;
		ccpt_rsp_type code;
	} ccpt_vdm_rsp_type;

endpackage

// ---- ccpt_port_timing.sv ----
// Connection timing, level classification and mode message control
`timescale 1ns/1ps
// Overview of operation
// - Attached source turns VBUS on at once
// - Source removes and discharges VBUS on detach
// - VCONN follows VBUS within 2 ms
// - Powered accessory sources VCONN on entry
// - VCONN off and discharged on detach/command
// - Sink current follows advertisement after debounce
// - Toggle period held between 50 and 100 ms
// - Source share of period 30 to 70%
// - Role switch completes within 1 ms
// - Try-source wait lasts 75 to 150 ms
// - Try-sink wait lasts 400 to 800 ms
// - Toggle timing dithered, not precisely locked
// - Attach needs 100 to 200 ms stable
// - Sink detach or current change debounced 10-20 ms
// - Error recovery held at least 25 ms
// - Source cable threshold follows own advertisement
// - Source sink band up to 1.60/2.60 V
// - Default-only sink: below 0.2 V is cable
// - Decoding sink splits at 0.66 and 1.23 V
// - Mode messages never inside power negotiation
// - One answer per request, enter only on ACK
// - Cable and device modes active together
module ccpt_port_timing import ccpt_pkg::*; #(
	parameter int CYCLES_PER_MS = CYC_PER_MS
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire ccpt_cmp_type cmp_i,
	input wire logic drp_en_i,
	input wire logic src_pref_i,
	input wire logic try_src_en_i,
	input wire logic acc_en_i,
	input wire logic snk_decode_i,
	input wire ccpt_adv_type adv_cfg_i,
	input wire logic vconn_req_i,
	input wire logic vconn_off_cmd_i,
	input wire logic err_i,
	input wire logic pd_neg_busy_i,
	input wire logic vdm_req_vld_i,
	input wire ccpt_vdm_req_type vdm_req_i,
	input wire logic vdm_rsp_vld_i,
	input wire ccpt_vdm_rsp_type vdm_rsp_i,
	output ccpt_state_type state_o,
	output logic rp_en_o,
	output logic rd_en_o,
	output logic vbus_en_o,
	output logic vbus_dis_o,
	output logic vconn_en_o,
	output logic vconn_dis_o,
	output logic attached_o,
	output ccpt_adv_type snk_adv_o,
	output ccpt_cls_type cls_o,
	output logic vdm_send_o,
	output logic vdm_refuse_o,
	output logic vdm_perr_o,
	output logic [1:0] mode_active_o
);
	ccpt_state_type state_reg, st_next;
	ccpt_cmp_type cmp_s1_reg, cmp_s2_reg;
	ccpt_cls_type cls_last_reg, cls_now;
	ccpt_adv_type snk_adv_reg;
	logic [15:0] pre_cnt_reg;
	logic ms_tick_reg;
	logic [7:0] lfsr_reg;
	logic rp_en_reg, rd_en_reg, vbus_en_reg, vbus_dis_reg;
	logic vconn_en_reg, vconn_dis_reg, attached_reg;
	logic send_reg, refuse_reg, perr_reg;
	logic [1:0] pend_reg, enter_reg, mode_reg;
	logic [1:0] send_w, refuse_w, perr_w;
	logic [7:0] er_ms_reg;
	logic boot_reg;

	// Free-running prescaler and jitter source
	wire pre_wrap = pre_cnt_reg == 16'(CYCLES_PER_MS - 1);
	wire lfsr_fb = lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3];

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pre_cnt_reg <= 16'h0000;
			ms_tick_reg <= 1'b0;
			lfsr_reg <= LFSR_SEED;
			boot_reg <= 1'b1;
		end else begin
			pre_cnt_reg <= pre_wrap ? 16'h0000 : 16'(pre_cnt_reg + 1'b1);
			ms_tick_reg <= pre_wrap;
			lfsr_reg <= {lfsr_reg[6:0], lfsr_fb};
			boot_reg <= 1'b0;
		end
	end

	// Two-flop synchroniser; only the second stage feeds the decode
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cmp_s1_reg <= '0;
			cmp_s2_reg <= '0;
		end else begin
			cmp_s1_reg <= cmp_i;
			cmp_s2_reg <= cmp_s1_reg;
		end
	end

	// Source-side thresholds picked by our own advertisement
	wire adv3 = adv_cfg_i == ADV_3P0;
	wire adv15 = adv_cfg_i == ADV_1P5;
	wire above_ra = adv3 ? cmp_s2_reg.gt_0p80 : adv15 ? cmp_s2_reg.gt_0p40 :
		cmp_s2_reg.gt_0p20;
	wire above_rd = adv3 ? cmp_s2_reg.gt_2p60 : cmp_s2_reg.gt_1p60;
	wire ccpt_cls_type cls_src = !above_ra ? CL_RA : !above_rd ? CL_RD : CL_OPEN;

	// Sink side: below 0.2 V means only a cable, never a source
	wire ccpt_cls_type cls_dec = !cmp_s2_reg.gt_0p66 ? CL_SRC_DEF :
		!cmp_s2_reg.gt_1p23 ? CL_SRC_1P5 : CL_SRC_3P0;
	wire ccpt_cls_type cls_snk = !cmp_s2_reg.gt_0p20 ? CL_RA :
		snk_decode_i ? cls_dec : CL_SRC_DEF;
	assign cls_now = rp_en_reg ? cls_src : cls_snk;

	// Decode of the current level
	wire is_src_cls = cls_now == CL_SRC_DEF || cls_now == CL_SRC_1P5 ||
		cls_now == CL_SRC_3P0;
	wire is_rd = cls_now == CL_RD;
	wire is_ra_acc = cls_now == CL_RA && acc_en_i;
	wire cls_chg = cls_now != cls_last_reg;
	wire st_chg = st_next != state_reg;

	// Timers: state wait, debounce and the two discharges
	logic st_done, db_done, vbd_done, vcd_done;
	ccpt_ms_type st_load, db_load;
	wire attw = state_reg == ST_ATTW_SRC || state_reg == ST_ATTW_SNK;
	wire nx_attw = st_next == ST_ATTW_SRC || st_next == ST_ATTW_SNK;
	wire leave_src = state_reg == ST_ATT_SRC && st_next != ST_ATT_SRC;
	wire vconn_on = !vconn_off_cmd_i && ((st_next == ST_ATT_SRC && vconn_req_i)
		|| st_next == ST_PWR_ACC);
	wire vconn_fall = vconn_en_reg && !vconn_on;
	wire db_start = cls_chg || st_chg;
	// Arm the wait once after reset, else a port toggling from reset never leaves
	wire st_start = st_chg || boot_reg;
	// Attach wait uses the long debounce, all else the short one
	assign db_load = (st_chg ? nx_attw : attw) ? T_CC_DB_MS : T_PD_DB_MS;

	// Per-state wait; source share of each toggle is dithered
	always_comb begin
		case (st_next)
			ST_UNATT_SRC: st_load = TMR_W'(T_SRC_BASE_MS + lfsr_reg[3:0]);
			ST_UNATT_SNK: st_load = T_SNK_MS;
			ST_TRY_SRC: st_load = T_TRY_MS;
			ST_TRY_WAIT_SNK: st_load = T_TRY_WAIT_MS;
			ST_ERR_REC: st_load = T_ERR_REC_MS;
			default: st_load = T_PD_DB_MS;
		endcase
	end

	ccpt_ms_timer u_st_tmr (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.ms_tick_i(ms_tick_reg),
		.start_i(st_start),
		.load_i(st_load),
		.done_o(st_done)
	);

	ccpt_ms_timer u_db_tmr (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.ms_tick_i(ms_tick_reg),
		.start_i(db_start),
		.load_i(db_load),
		.done_o(db_done)
	);

	ccpt_ms_timer u_vbd_tmr (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.ms_tick_i(ms_tick_reg),
		.start_i(leave_src),
		.load_i(T_VBUS_DIS_MS),
		.done_o(vbd_done)
	);

	ccpt_ms_timer u_vcd_tmr (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.ms_tick_i(ms_tick_reg),
		.start_i(vconn_fall),
		.load_i(T_VCONN_DIS_MS),
		.done_o(vcd_done)
	);

	// Debounce is only valid when the level has not changed this cycle
	wire stable = db_done && !cls_chg;
	wire to_src = drp_en_i ? st_done : src_pref_i;
	wire to_snk = drp_en_i ? st_done : !src_pref_i;

	// Connection state machine
	always_comb begin
		st_next = state_reg;
		case (state_reg)
			ST_UNATT_SRC: begin
				if (is_rd || is_ra_acc)
					st_next = ST_ATTW_SRC;
				else if (to_snk)
					st_next = ST_UNATT_SNK;
			end
			ST_UNATT_SNK: begin
				if (is_src_cls)
					st_next = ST_ATTW_SNK;
				else if (to_src)
					st_next = ST_UNATT_SRC;
			end
			ST_ATTW_SRC: begin
				if (!is_rd && !is_ra_acc)
					st_next = ST_UNATT_SRC;
				else if (stable)
					st_next = is_rd ? ST_ATT_SRC : ST_PWR_ACC;
			end
			ST_ATTW_SNK: begin
				if (!is_src_cls)
					st_next = ST_UNATT_SNK;
				else if (stable)
					st_next = try_src_en_i ? ST_TRY_SRC : ST_ATT_SNK;
			end
			ST_TRY_SRC: begin
				if (is_rd && stable)
					st_next = ST_ATT_SRC;
				else if (st_done)
					st_next = ST_TRY_WAIT_SNK;
			end
			ST_TRY_WAIT_SNK: begin
				if (is_src_cls && stable)
					st_next = ST_ATT_SNK;
				else if (st_done)
					st_next = ST_UNATT_SNK;
			end
			ST_ATT_SRC: begin
				if (!is_rd)
					st_next = ST_UNATT_SRC;
			end
			ST_ATT_SNK: begin
				if (!is_src_cls && stable)
					st_next = ST_UNATT_SNK;
			end
			ST_PWR_ACC: begin
				if (cls_now == CL_OPEN && stable)
					st_next = ST_UNATT_SRC;
			end
			ST_ERR_REC: begin
				if (st_done)
					st_next = (drp_en_i || src_pref_i) ? ST_UNATT_SRC : ST_UNATT_SNK;
			end
			default: st_next = ST_UNATT_SNK;
		endcase
		if (err_i)
			st_next = ST_ERR_REC;
	end

	// Terminations follow the next state so the switch takes one cycle
	wire nx_rp = st_next inside {ST_UNATT_SRC, ST_ATTW_SRC, ST_ATT_SRC, ST_TRY_SRC, ST_PWR_ACC};
	wire nx_rd = st_next inside {ST_UNATT_SNK, ST_ATTW_SNK, ST_ATT_SNK, ST_TRY_WAIT_SNK};
	wire nx_att = st_next inside {ST_ATT_SRC, ST_ATT_SNK, ST_PWR_ACC};
	wire ccpt_adv_type adv_of_cls = cls_now == CL_SRC_3P0 ? ADV_3P0 :
		cls_now == CL_SRC_1P5 ? ADV_1P5 : ADV_DEF;
	wire adv_upd = st_next == ST_ATT_SNK && is_src_cls && stable;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= ST_UNATT_SNK;
			cls_last_reg <= CL_OPEN;
			rp_en_reg <= 1'b0;
			rd_en_reg <= 1'b1;
			attached_reg <= 1'b0;
		end else begin
			state_reg <= st_next;
			cls_last_reg <= cls_now;
			rp_en_reg <= nx_rp;
			rd_en_reg <= nx_rd;
			attached_reg <= nx_att;
		end
	end

	// Sink current limit, reset to default whenever not attached
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			snk_adv_reg <= ADV_DEF;
		else if (adv_upd)
			snk_adv_reg <= adv_of_cls;
		else if (!nx_att)
			snk_adv_reg <= ADV_DEF;
	end

	// Supplies: on at state entry, discharge held for a fixed time
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			vbus_en_reg <= 1'b0;
			vbus_dis_reg <= 1'b0;
			vconn_en_reg <= 1'b0;
			vconn_dis_reg <= 1'b0;
		end else begin
			vbus_en_reg <= st_next == ST_ATT_SRC;
			vconn_en_reg <= vconn_on;
			if (leave_src)
				vbus_dis_reg <= 1'b1;
			else if (vbd_done)
				vbus_dis_reg <= 1'b0;
			if (vconn_fall)
				vconn_dis_reg <= 1'b1;
			else if (vcd_done)
				vconn_dis_reg <= 1'b0;
		end
	end

	// One request tracker per slot: cable and partner run independently
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_slot
			wire req_g = vdm_req_vld_i && vdm_req_i.slot == 1'(g);
			wire rsp_g = vdm_rsp_vld_i && vdm_rsp_i.slot == 1'(g);
			wire ack_g = rsp_g && pend_reg[g] && vdm_rsp_i.code == RSP_ACK;
			// Held back while power negotiation runs or one is outstanding
			assign send_w[g] = req_g && attached_reg && !pd_neg_busy_i && !pend_reg[g];
			assign refuse_w[g] = req_g && !send_w[g];
			assign perr_w[g] = rsp_g && !pend_reg[g];
			always_ff @(posedge core_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					pend_reg[g] <= 1'b0;
					enter_reg[g] <= 1'b0;
					mode_reg[g] <= 1'b0;
				end else if (!nx_att) begin
					pend_reg[g] <= 1'b0;
					mode_reg[g] <= 1'b0;
				end else begin
					if (send_w[g]) begin
						pend_reg[g] <= 1'b1;
						enter_reg[g] <= vdm_req_i.enter;
					end else if (rsp_g)
						pend_reg[g] <= 1'b0;
					if (ack_g)
						mode_reg[g] <= enter_reg[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			send_reg <= 1'b0;
			refuse_reg <= 1'b0;
			perr_reg <= 1'b0;
		end else begin
			send_reg <= |send_w;
			refuse_reg <= |refuse_w;
			perr_reg <= |perr_w;
		end
	end

	// Time spent in error recovery, for the check below
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			er_ms_reg <= 8'h00;
		else if (state_reg != ST_ERR_REC)
			er_ms_reg <= 8'h00;
		else if (ms_tick_reg && er_ms_reg != 8'hff)
			er_ms_reg <= 8'(er_ms_reg + 1'b1);
	end

	assign state_o = state_reg;
	assign rp_en_o = rp_en_reg;
	assign rd_en_o = rd_en_reg;
	assign vbus_en_o = vbus_en_reg;
	assign vbus_dis_o = vbus_dis_reg;
	assign vconn_en_o = vconn_en_reg;
	assign vconn_dis_o = vconn_dis_reg;
	assign attached_o = attached_reg;
	assign snk_adv_o = snk_adv_reg;
	assign cls_o = cls_last_reg;
	assign vdm_send_o = send_reg;
	assign vdm_refuse_o = refuse_reg;
	assign vdm_perr_o = perr_reg;
	assign mode_active_o = mode_reg;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_leave_src;
		state_reg == ST_ATT_SRC ##1 state_reg != ST_ATT_SRC;
	endsequence

	sequence s_toggle_snk;
		state_reg == ST_UNATT_SRC ##1 state_reg == ST_UNATT_SNK;
	endsequence

	property p_vbus_on;
		state_reg != ST_ATT_SRC && st_next == ST_ATT_SRC |=> vbus_en_o;
	endproperty
	a_vbus_on: assert property (p_vbus_on) else $error("vbus late");

	property p_vbus_off;
		s_leave_src |-> !vbus_en_o && vbus_dis_o;
	endproperty
	a_vbus_off: assert property (p_vbus_off) else $error("vbus not removed");

	property p_vconn_src;
		state_reg == ST_ATT_SRC && vbus_en_o && vconn_req_i && !vconn_off_cmd_i
			|=> vconn_en_o || !vbus_en_o;
	endproperty
	a_vconn_src: assert property (p_vconn_src) else $error("vconn late");

	property p_vconn_acc;
		state_reg == ST_PWR_ACC && !$past(vconn_off_cmd_i) |-> vconn_en_o;
	endproperty
	a_vconn_acc: assert property (p_vconn_acc) else $error("acc vconn off");

	property p_vconn_off;
		$fell(vconn_en_o) |-> vconn_dis_o;
	endproperty
	a_vconn_off: assert property (p_vconn_off) else $error("no vconn discharge");

	property p_role_switch;
		s_toggle_snk |-> rd_en_o && !rp_en_o;
	endproperty
	a_role_switch: assert property (p_role_switch) else $error("role switch slow");

	property p_fast_exit;
		state_reg == ST_ATT_SRC && cls_now != CL_RD && !err_i |=> state_reg == ST_UNATT_SRC;
	endproperty
	a_fast_exit: assert property (p_fast_exit) else $error("source exit slow");

	property p_err_hold;
		state_reg == ST_ERR_REC && st_next != ST_ERR_REC |-> er_ms_reg >= T_ERR_MIN_MS;
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error recovery short");

	property p_vdm_neg;
		vdm_send_o |-> !$past(pd_neg_busy_i);
	endproperty
	a_vdm_neg: assert property (p_vdm_neg) else $error("request in negotiation");

	property p_mode_ack;
		$rose(mode_active_o[0]) |-> $past(vdm_rsp_vld_i && vdm_rsp_i.code == RSP_ACK);
	endproperty
	a_mode_ack: assert property (p_mode_ack) else $error("mode without ack");
endmodule

// ---- tb.sv ----
// Self-checking bench for the connection timing block
`timescale 1ns/1ps
module tb import ccpt_pkg::*;;
	// Short millisecond keeps every wait within a few thousand cycles
	localparam int CPM = 4;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic drp_en = 1'b0, src_pref = 1'b0, acc_en = 1'b0, snk_dec = 1'b0, vconn_req = 1'b0;
	logic err = 1'b0, pd_busy = 1'b0, req_vld = 1'b0, rsp_vld = 1'b0;
	logic try_src = 1'b0, vconn_off = 1'b0;
	ccpt_adv_type adv = ADV_DEF, src_adv = ADV_DEF;
	ccpt_vdm_req_type req = '0;
	ccpt_vdm_rsp_type rsp = '0;
	logic [1:0] kind = 2'h0;
	ccpt_cmp_type cmp;
	ccpt_state_type state_o;
	logic rp_en_o, rd_en_o, vbus_en_o, vbus_dis_o, vconn_en_o, vconn_dis_o, attached_o;
	ccpt_adv_type snk_adv_o;
	ccpt_cls_type cls_o;
	logic vdm_send_o, vdm_refuse_o, vdm_perr_o;
	logic [1:0] mode_active_o;
	int err_total = 0, checks = 0;

	// 40 MHz clock
	always #12.5 clk = ~clk;

	// Block under test and its far end
	ccpt_port_timing #(.CYCLES_PER_MS(CPM)) ccpt_port_timing_inst (
		.core_clk_i(clk), .rst_n_i(rst_n), .cmp_i(cmp), .drp_en_i(drp_en),
		.src_pref_i(src_pref), .try_src_en_i(try_src), .acc_en_i(acc_en), .snk_decode_i(snk_dec),
		.adv_cfg_i(adv), .vconn_req_i(vconn_req), .vconn_off_cmd_i(vconn_off), .err_i(err),
		.pd_neg_busy_i(pd_busy), .vdm_req_vld_i(req_vld), .vdm_req_i(req),
		.vdm_rsp_vld_i(rsp_vld), .vdm_rsp_i(rsp), .state_o(state_o), .rp_en_o(rp_en_o),
		.rd_en_o(rd_en_o), .vbus_en_o(vbus_en_o), .vbus_dis_o(vbus_dis_o),
		.vconn_en_o(vconn_en_o), .vconn_dis_o(vconn_dis_o), .attached_o(attached_o),
		.snk_adv_o(snk_adv_o), .cls_o(cls_o), .vdm_send_o(vdm_send_o),
		.vdm_refuse_o(vdm_refuse_o), .vdm_perr_o(vdm_perr_o), .mode_active_o(mode_active_o)
	);
	ccpt_partner_model ccpt_partner_model_inst (
		.rp_en_i(rp_en_o), .rd_en_i(rd_en_o), .adv_cfg_i(adv), .kind_i(kind),
		.src_adv_i(src_adv), .cmp_o(cmp)
	);

	// Compare helpers
	task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %0h, seen %0h", what, exp, got);
		end
	endtask
	task automatic chk_rng(input string what, input int lo, input int hi, input int got);
		checks++;
		if (got < lo || got > hi) begin
			err_total++;
			$display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
		end
	endtask

	// Counts falling edges until the state shows up, at most lim
	task automatic wait_state(input ccpt_state_type s, input int lim, output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (state_o !== s && n < lim);
	endtask

	// One mode request or response, then its pulse and the mode flags
	task automatic vdm(input logic is_rsp, input logic slot, input logic ent,
			input ccpt_rsp_type code, input logic exp_p, input logic [1:0] exp_m);
		logic a, b;
		a = 1'b0;
		b = 1'b0;
		@(posedge clk);
		req_vld <= !is_rsp;
		rsp_vld <= is_rsp;
		req <= '{slot: slot, enter: ent};
		rsp <= '{slot: slot, code: code};
		@(posedge clk);
		req_vld <= 1'b0;
		rsp_vld <= 1'b0;
		repeat (2) begin
			@(negedge clk);
			a = a | (is_rsp ? vdm_perr_o : vdm_send_o);
			b = b | vdm_refuse_o;
		end
		chk_val("vdm pulse", exp_p, a);
		chk_val("vdm refuse", is_rsp ? 1'b0 : !exp_p, b);
		chk_val("mode active", exp_m, mode_active_o);
	endtask

	task automatic t_cls();
		ccpt_cls_type exp [3] = '{CL_RA, CL_RD, CL_OPEN};
		@(posedge clk);
		src_pref <= 1'b1;
		for (int a = 0; a < 3; a++) begin
			for (int k = 0; k < 3; k++) begin
				@(posedge clk);
				adv <= ccpt_adv_type'(a);
				kind <= 2'(2 - k);
				repeat (6) @(negedge clk);
				chk_val("source cls", exp[k], cls_o);
			end
		end
		$display("test source classes done");
	endtask

	task automatic t_src_attach();
		int n;
		vdm(1'b0, 1'b0, 1'b1, RSP_ACK, 1'b0, 2'b00);
		@(posedge clk);
		vconn_req <= 1'b1;
		kind <= 2'h1;
		wait_state(ST_ATT_SRC, 1000, n);
		chk_rng("attach wait", 100 * CPM, 200 * CPM, n);
		chk_val("vbus on", 1'b1, vbus_en_o);
		chk_val("vconn on", 1'b1, vconn_en_o);
		chk_val("attached cls", CL_RD, cls_o);
		// Commanded VCONN off while attached, then allowed back on
		@(posedge clk);
		vconn_off <= 1'b1;
		repeat (2) @(negedge clk);
		chk_val("vconn command", 2'b01, {vconn_en_o, vconn_dis_o});
		@(posedge clk);
		vconn_off <= 1'b0;
		$display("test source attach done");
	endtask

	task automatic t_vdm();
		@(posedge clk);
		pd_busy <= 1'b1;
		vdm(1'b0, 1'b0, 1'b1, RSP_ACK, 1'b0, 2'b00);
		@(posedge clk);
		pd_busy <= 1'b0;
		vdm(1'b0, 1'b0, 1'b1, RSP_ACK, 1'b1, 2'b00);
		vdm(1'b0, 1'b0, 1'b1, RSP_ACK, 1'b0, 2'b00);
		vdm(1'b1, 1'b0, 1'b0, RSP_ACK, 1'b0, 2'b01);
		for (int i = 0; i < 3; i++) begin
			vdm(1'b0, 1'b1, 1'b1, RSP_ACK, 1'b1, 2'b01);
			vdm(1'b1, 1'b1, 1'b0, ccpt_rsp_type'(2 - i), 1'b0, {i == 2, 1'b1});
		end
		vdm(1'b1, 1'b0, 1'b0, RSP_ACK, 1'b1, 2'b11);
		vdm(1'b0, 1'b0, 1'b0, RSP_ACK, 1'b1, 2'b11);
		vdm(1'b1, 1'b0, 1'b0, RSP_ACK, 1'b0, 2'b10);
		$display("test mode messages done");
	endtask

	task automatic t_src_detach();
		int n, nv, nc;
		@(posedge clk);
		kind <= 2'h0;
		wait_state(ST_UNATT_SRC, 20, n);
		chk_rng("source exit", 1, 8, n);
		chk_val("power off", 2'b00, {vbus_en_o, vconn_en_o});
		chk_val("modes cleared", 2'b00, mode_active_o);
		nv = 0;
		nc = 0;
		while (vbus_dis_o === 1'b1 && nv < 3000) begin
			nc += int'(vconn_dis_o === 1'b1);
			nv++;
			@(negedge clk);
		end
		chk_rng("vbus discharge", 1, 650 * CPM, nv);
		chk_rng("vconn discharge", 1, 35 * CPM, nc);
		$display("test source detach done");
	endtask

	// Jitter makes periods differ, so only the bounds are judged
	task automatic t_toggle();
		int h, l, bad;
		@(posedge clk);
		drp_en <= 1'b1;
		h = 0;
		while (rp_en_o !== 1'b0 && h < 800) begin
			@(negedge clk);
			h++;
		end
		while (rp_en_o !== 1'b1 && h < 1600) begin
			@(negedge clk);
			h++;
		end
		repeat (3) begin
			h = 0;
			l = 0;
			bad = 0;
			while (rp_en_o === 1'b1 && h < 800) begin
				bad += int'(rd_en_o !== 1'b0);
				h++;
				@(negedge clk);
			end
			while (rp_en_o !== 1'b1 && l < 800) begin
				bad += int'(rd_en_o !== 1'b1);
				l++;
				@(negedge clk);
			end
			chk_rng("toggle period", 50 * CPM, 100 * CPM, h + l);
			chk_rng("source share", 30, 70, h * 100 / (h + l));
			chk_rng("role overlap", 0, 0, bad);
		end
		$display("test toggle done");
	endtask

	task automatic t_sink();
		ccpt_adv_type seq [3] = '{ADV_3P0, ADV_1P5, ADV_DEF};
		int n;
		@(posedge clk);
		drp_en <= 1'b0;
		src_pref <= 1'b0;
		snk_dec <= 1'b1;
		wait_state(ST_UNATT_SNK, 400, n);
		@(posedge clk);
		kind <= 2'h3;
		wait_state(ST_ATT_SNK, 1000, n);
		chk_rng("sink attach wait", 100 * CPM, 200 * CPM, n);
		foreach (seq[i]) begin
			@(posedge clk);
			src_adv <= seq[i];
			n = 0;
			while (snk_adv_o !== seq[i] && n < 400) begin
				@(negedge clk);
				n++;
			end
			chk_rng("sink adjust", 10 * CPM, 60 * CPM, n);
			chk_val("sink cls", CL_SRC_DEF + seq[i], cls_o);
		end
		@(posedge clk);
		snk_dec <= 1'b0;
		src_adv <= ADV_3P0;
		repeat (80 * CPM) @(negedge clk);
		chk_val("default-only cls", CL_SRC_DEF, cls_o);
		chk_val("default-only adv", ADV_DEF, snk_adv_o);
		@(posedge clk);
		kind <= 2'h0;
		n = 0;
		while (attached_o === 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		chk_rng("sink detach", 10 * CPM, 20 * CPM + 8, n);
		$display("test sink done");
	endtask

	// Try-source finds no sink, then try-wait finds no source
	task automatic t_try();
		int n;
		@(posedge clk);
		try_src <= 1'b1;
		kind <= 2'h3;
		wait_state(ST_TRY_SRC, 1000, n);
		@(posedge clk);
		kind <= 2'h0;
		wait_state(ST_TRY_WAIT_SNK, 800, n);
		chk_rng("try-source wait", 75 * CPM, 150 * CPM, n);
		wait_state(ST_UNATT_SNK, 4000, n);
		chk_rng("try-sink wait", 400 * CPM, 800 * CPM, n);
		$display("test try roles done");
	endtask

	task automatic t_err_acc();
		int n;
		@(posedge clk);
		err <= 1'b1;
		@(posedge clk);
		err <= 1'b0;
		wait_state(ST_ERR_REC, 4, n);
		chk_val("recovery terms", 2'b00, {rp_en_o, rd_en_o});
		n = 0;
		while (state_o === ST_ERR_REC && n < 400) begin
			@(negedge clk);
			n++;
		end
		chk_rng("recovery hold", 25 * CPM, 200, n);
		@(posedge clk);
		src_pref <= 1'b1;
		acc_en <= 1'b1;
		kind <= 2'h2;
		wait_state(ST_PWR_ACC, 1200, n);
		chk_val("accessory state", ST_PWR_ACC, state_o);
		n = 0;
		while (vconn_en_o !== 1'b1 && n < 500) begin
			@(negedge clk);
			n++;
		end
		chk_rng("accessory vconn", 0, 100 * CPM, n);
		$display("test recovery and accessory done");
	endtask

	// Verdict and end of run
	task automatic results();
		$display("checks %0d, mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Main sequence; reset values are looked at while reset is still held
	initial begin
		repeat (11) @(posedge clk);
		chk_val("reset state", {ST_UNATT_SNK, 2'b01}, {state_o, rp_en_o, rd_en_o});
		chk_val("reset power", 4'h0, {vbus_en_o, vbus_dis_o, vconn_en_o, vconn_dis_o});
		@(posedge clk);
		rst_n <= 1'b1;
		t_cls();
		t_src_attach();
		t_vdm();
		t_src_detach();
		t_toggle();
		t_sink();
		t_try();
		t_err_acc();
		results();
	end

	// Watchdog, about four times the expected run
	initial begin
		repeat (40000) @(posedge clk);
		err_total++;
		$display("unexpected run length: expected end, seen watchdog");
		results();
	end
endmodule
